// ==== logic/tts_pkg.sv ====
// Constants and types shared by the threshold trigger set
package tts_pkg;
   // Clock and timebase
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIMEBASE_MS = 10;
   localparam int TIMEBASE_CYCLES = TIMEBASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TICK_W = 17;

   // Gate time in units of the timebase (0.05 s .. 99.99 s)
   localparam int GATE_W = 14;
   localparam logic [13:0] GATE_MIN = 14'h0005;
   localparam logic [13:0] GATE_MAX = 14'h270f;

   // Frequency thresholds and pulse counter
   localparam int FTHR_W = 14;
   localparam logic [13:0] FTHR_MAX = 14'h270f;
   localparam int CNT_W = 18;
   localparam logic [17:0] CNT_MAX = 18'h3ffff;

   // Analog scaling
   localparam int ANA_W = 10;
   localparam logic [9:0] ANA_FULL = 10'h3e8;
   localparam int GAIN_W = 11;
   localparam logic [10:0] GAIN_MAX = 11'h3e8;
   localparam logic [20:0] GAIN_DIV = 21'h000064;
   localparam int OFS_W = 15;
   localparam logic signed [14:0] OFS_LIM = 15'sh2710;
   localparam int VAL_W = 18;

   typedef logic signed [VAL_W-1:0] tts_val_t;
   typedef logic signed [VAL_W:0] tts_cmp_t;
endpackage

// ==== logic/tts_scale_if.sv ====
// Interface between a trigger and its analog scaling unit
`timescale 1ns/1ps
`default_nettype none
interface tts_scale_if;
   logic [tts_pkg::ANA_W-1:0] raw;
   logic [tts_pkg::GAIN_W-1:0] gain;
   logic signed [tts_pkg::OFS_W-1:0] offset;
   tts_pkg::tts_val_t actual;
   modport src (output raw, output gain, output offset, input actual);
   modport scaler (input raw, input gain, input offset, output actual);
endinterface
`default_nettype wire

// ==== logic/tts_scaler.sv ====
// Analog scaling unit: gain and offset applied to an input, result registered
`timescale 1ns/1ps
`default_nettype none
module tts_scaler (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Scaling channel
   tts_scale_if.scaler sc
);
   logic [tts_pkg::ANA_W-1:0] raw_c;
   logic [tts_pkg::GAIN_W-1:0] gain_c;
   logic signed [tts_pkg::OFS_W-1:0] ofs_c;
   logic [20:0] prod;
   logic [20:0] quot;
   tts_pkg::tts_val_t actual_ff;
   tts_pkg::tts_val_t nxt_actual;

   always_comb begin
      // Out-of-range settings snap to the nearest valid value
      raw_c = (sc.raw > tts_pkg::ANA_FULL) ? tts_pkg::ANA_FULL : sc.raw;
      gain_c = (sc.gain > tts_pkg::GAIN_MAX) ? tts_pkg::GAIN_MAX : sc.gain;
      if (sc.offset > tts_pkg::OFS_LIM) begin
         ofs_c = tts_pkg::OFS_LIM;
      end else if (sc.offset < -tts_pkg::OFS_LIM) begin
         ofs_c = -tts_pkg::OFS_LIM;
      end else begin
         ofs_c = sc.offset;
      end
      // Gain is in hundredths; the quotient truncates toward zero
      prod = 21'(raw_c) * 21'(gain_c);
      quot = prod / tts_pkg::GAIN_DIV;
      nxt_actual = $signed({1'b0, quot[16:0]}) + tts_pkg::VAL_W'(ofs_c);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         actual_ff <= '0;
      end else begin
         actual_ff <= nxt_actual;
      end
   end

   assign sc.actual = actual_ff;
endmodule
`default_nettype wire

// ==== logic/tts_top.sv ====
// Threshold trigger set: frequency, analog and differential triggers
`timescale 1ns/1ps
`default_nettype none
module tts_top #(
   parameter int unsigned TICK_CYCLES = tts_pkg::TIMEBASE_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Frequency trigger
   input wire logic pulse_in,
   input wire logic [tts_pkg::GATE_W-1:0] gate_time,
   input wire logic [tts_pkg::FTHR_W-1:0] freq_on,
   input wire logic [tts_pkg::FTHR_W-1:0] freq_off,
   output logic freq_q,
   output logic [tts_pkg::CNT_W-1:0] freq_rate,
   // Analog threshold trigger
   input wire logic [tts_pkg::ANA_W-1:0] analog_in,
   input wire logic [tts_pkg::GAIN_W-1:0] ana_gain,
   input wire logic signed [tts_pkg::OFS_W-1:0] ana_offset,
   input wire tts_pkg::tts_val_t ana_on,
   input wire tts_pkg::tts_val_t ana_off,
   output logic ana_q,
   output tts_pkg::tts_val_t ana_actual,
   // Analog differential trigger
   input wire logic [tts_pkg::GAIN_W-1:0] diff_gain,
   input wire logic signed [tts_pkg::OFS_W-1:0] diff_offset,
   input wire tts_pkg::tts_val_t diff_on,
   input wire tts_pkg::tts_val_t diff_delta,
   output logic diff_q,
   output tts_pkg::tts_val_t diff_actual
);
   ////////////////////////////////////////////////////////////////////////
   // Shared comparison: hysteresis when on >= off, window otherwise.
   // strict selects a clear on value < off instead of value <= off.
   function automatic logic decide(
      input tts_pkg::tts_cmp_t val,
      input tts_pkg::tts_cmp_t on,
      input tts_pkg::tts_cmp_t off,
      input logic q,
      input logic strict
   );
      logic res;
      res = q;
      if (on >= off) begin
         if (val > on) begin
            res = 1'b1;
         end else if (strict ? (val < off) : (val <= off)) begin
            res = 1'b0;
         end else begin
            res = q;
         end
      end else begin
         res = (on <= val) && (val < off);
      end
      return res;
   endfunction

   // Frequency thresholds above the top of their range act as the top
   function automatic logic [tts_pkg::FTHR_W-1:0] clamp_thr(
      input logic [tts_pkg::FTHR_W-1:0] thr
   );
      return (thr > tts_pkg::FTHR_MAX) ? tts_pkg::FTHR_MAX : thr;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Frequency trigger
   logic pulse_prev_ff;
   logic [tts_pkg::TICK_W-1:0] tick_cnt_ff;
   logic [tts_pkg::GATE_W-1:0] gate_cnt_ff;
   logic [tts_pkg::CNT_W-1:0] pulse_cnt_ff;
   logic [tts_pkg::CNT_W-1:0] rate_ff;
   logic freq_q_ff;
   logic nxt_pulse_prev;
   logic [tts_pkg::TICK_W-1:0] nxt_tick_cnt;
   logic [tts_pkg::GATE_W-1:0] nxt_gate_cnt;
   logic [tts_pkg::CNT_W-1:0] nxt_pulse_cnt;
   logic [tts_pkg::CNT_W-1:0] nxt_rate;
   logic nxt_freq_q;
   logic rise;
   logic tick;
   logic gate_end;
   logic [tts_pkg::GATE_W-1:0] gate_lim;
   logic [tts_pkg::FTHR_W-1:0] fon_c;
   logic [tts_pkg::FTHR_W-1:0] foff_c;
   logic [tts_pkg::CNT_W-1:0] cnt_inc;

   // Timebase: one tick per 10 ms, gate length counted in ticks
   always_comb begin
      if (gate_time < tts_pkg::GATE_MIN) begin
         gate_lim = tts_pkg::GATE_MIN;
      end else if (gate_time > tts_pkg::GATE_MAX) begin
         gate_lim = tts_pkg::GATE_MAX;
      end else begin
         gate_lim = gate_time;
      end
      tick = (tick_cnt_ff == tts_pkg::TICK_W'(TICK_CYCLES - 1));
      nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
      // Gate length may change mid-interval; >= ends it without wrapping
      gate_end = tick && (gate_cnt_ff >= gate_lim - 1'b1);
      nxt_gate_cnt = gate_cnt_ff;
      if (tick) begin
         nxt_gate_cnt = gate_end ? '0 : gate_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_ff <= '0;
         gate_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         gate_cnt_ff <= nxt_gate_cnt;
      end
   end

   // Pulse counting and the once-per-gate decision
   always_comb begin
      nxt_pulse_prev = pulse_in;
      rise = pulse_in & ~pulse_prev_ff;
      fon_c = clamp_thr(freq_on);
      foff_c = clamp_thr(freq_off);
      // Saturate rather than wrap on an over-fast source
      cnt_inc = pulse_cnt_ff;
      if (rise && (pulse_cnt_ff != tts_pkg::CNT_MAX)) begin
         cnt_inc = pulse_cnt_ff + 1'b1;
      end
      nxt_pulse_cnt = cnt_inc;
      nxt_rate = rate_ff;
      nxt_freq_q = freq_q_ff;
      if (gate_end) begin
         nxt_rate = cnt_inc;
         nxt_pulse_cnt = '0;
         nxt_freq_q = decide($signed({1'b0, cnt_inc}),
                             $signed({5'h00, fon_c}),
                             $signed({5'h00, foff_c}),
                             freq_q_ff, 1'b0);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_prev_ff <= 1'b0;
         pulse_cnt_ff <= '0;
         rate_ff <= '0;
         freq_q_ff <= 1'b0;
      end else begin
         pulse_prev_ff <= nxt_pulse_prev;
         pulse_cnt_ff <= nxt_pulse_cnt;
         rate_ff <= nxt_rate;
         freq_q_ff <= nxt_freq_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog scaling for both analog triggers
   tts_scale_if sc_thr ();
   tts_scale_if sc_dif ();

   assign sc_thr.raw = analog_in;
   assign sc_thr.gain = ana_gain;
   assign sc_thr.offset = ana_offset;
   assign sc_dif.raw = analog_in;
   assign sc_dif.gain = diff_gain;
   assign sc_dif.offset = diff_offset;

   tts_scaler u_scale_thr (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sc(sc_thr.scaler)
   );

   tts_scaler u_scale_dif (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sc(sc_dif.scaler)
   );

   ////////////////////////////////////////////////////////////////////////
   // Analog threshold and differential triggers, evaluated every cycle
   logic ana_q_ff;
   logic diff_q_ff;
   logic nxt_ana_q;
   logic nxt_diff_q;
   tts_pkg::tts_cmp_t diff_off;
   tts_pkg::tts_cmp_t thr_val;
   tts_pkg::tts_cmp_t thr_on;
   tts_pkg::tts_cmp_t thr_off;
   tts_pkg::tts_cmp_t dif_val;
   tts_pkg::tts_cmp_t dif_on;

   always_comb begin
      // One extra bit keeps On plus a full-range difference from wrapping
      thr_val = tts_pkg::tts_cmp_t'(sc_thr.actual);
      thr_on = tts_pkg::tts_cmp_t'(ana_on);
      thr_off = tts_pkg::tts_cmp_t'(ana_off);
      dif_val = tts_pkg::tts_cmp_t'(sc_dif.actual);
      dif_on = tts_pkg::tts_cmp_t'(diff_on);
      // Thresholds are plain integers; only the gain carries decimal scaling
      nxt_ana_q = decide(thr_val, thr_on, thr_off,
                         ana_q_ff, 1'b0);
      diff_off = dif_on + tts_pkg::tts_cmp_t'(diff_delta);
      nxt_diff_q = decide(dif_val, dif_on, diff_off,
                          diff_q_ff, 1'b1);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ana_q_ff <= 1'b0;
         diff_q_ff <= 1'b0;
      end else begin
         ana_q_ff <= nxt_ana_q;
         diff_q_ff <= nxt_diff_q;
      end
   end

   assign freq_q = freq_q_ff;
   assign freq_rate = rate_ff;
   assign ana_q = ana_q_ff;
   assign ana_actual = sc_thr.actual;
   assign diff_q = diff_q_ff;
   assign diff_actual = sc_dif.actual;
endmodule
`default_nettype wire

// ==== bench/tts_properties.sv ====
// Port checks for the threshold trigger set
`timescale 1ns/1ps
`default_nettype none
module tts_properties #(
   parameter int unsigned TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Frequency trigger
   input wire logic pulse_in,
   input wire logic [13:0] gate_time,
   input wire logic [13:0] freq_on,
   input wire logic [13:0] freq_off,
   input wire logic freq_q,
   input wire logic [17:0] freq_rate,
   // Analog triggers
   input wire tts_pkg::tts_val_t ana_on,
   input wire tts_pkg::tts_val_t ana_off,
   input wire logic ana_q,
   input wire tts_pkg::tts_val_t ana_actual,
   input wire tts_pkg::tts_val_t diff_on,
   input wire tts_pkg::tts_val_t diff_delta,
   input wire logic diff_q,
   input wire tts_pkg::tts_val_t diff_actual
);
   logic prev_ff, nxt_prev, gend;
   logic [17:0] cnt_ff, nxt_cnt, tot;
   logic [31:0] cyc_ff, nxt_cyc, glen;
   logic signed [18:0] doff;
   // Own gate timer, so gate ends are known even when the rate repeats
   always_comb begin
      glen = (gate_time < 14'h0005 ? 14'h0005 : gate_time) * TICK_CYCLES;
      gend = (cyc_ff == glen - 1);
      tot = cnt_ff + {17'h0, pulse_in & ~prev_ff};
      nxt_prev = pulse_in;
      nxt_cyc = gend ? '0 : cyc_ff + 1;
      nxt_cnt = gend ? '0 : tot;
      doff = diff_on + diff_delta;
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prev_ff <= 1'b0;
         cnt_ff <= '0;
         cyc_ff <= '0;
      end else begin
         prev_ff <= nxt_prev;
         cnt_ff <= nxt_cnt;
         cyc_ff <= nxt_cyc;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rate; gend |=> freq_rate == $past(tot); endproperty
   a_rate: assert property (p_rate)
      else $error("rate not the gate pulse count");
   property p_gate; !gend |=> $stable(freq_rate) && $stable(freq_q);
   endproperty
   a_gate: assert property (p_gate)
      else $error("frequency output moved inside a gate");
   property p_fset; gend && freq_on >= freq_off && tot > freq_on |=> freq_q;
   endproperty
   a_fset: assert property (p_fset)
      else $error("frequency output not set");
   property p_fclr; gend && (freq_on >= freq_off ? tot <= freq_off :
      tot < freq_on || tot >= freq_off) |=> !freq_q; endproperty
   a_fclr: assert property (p_fclr)
      else $error("frequency output not cleared");
   property p_aset; ana_on >= ana_off && ana_actual > ana_on |=> ana_q;
   endproperty
   a_aset: assert property (p_aset)
      else $error("analog output not set");
   property p_ahold; ana_on >= ana_off && ana_actual > ana_off &&
      ana_actual <= ana_on |=> $stable(ana_q); endproperty
   a_ahold: assert property (p_ahold)
      else $error("analog output left its held state");
   property p_aclr; (ana_on >= ana_off ? ana_actual <= ana_off :
      ana_actual < ana_on || ana_actual >= ana_off) |=> !ana_q; endproperty
   a_aclr: assert property (p_aclr)
      else $error("analog output not cleared");
   property p_awin; ana_on < ana_off && ana_actual >= ana_on &&
      ana_actual < ana_off |=> ana_q; endproperty
   a_awin: assert property (p_awin)
      else $error("analog window output not set");
   property p_dset; diff_delta <= 0 && diff_actual > diff_on |=> diff_q;
   endproperty
   a_dset: assert property (p_dset)
      else $error("differential output not set");
   property p_dclr; (diff_delta <= 0 ? diff_actual < doff :
      diff_actual < diff_on || diff_actual >= doff) |=> !diff_q; endproperty
   a_dclr: assert property (p_dclr)
      else $error("differential output not cleared");
   property p_dwin; diff_delta > 0 && diff_actual >= diff_on &&
      diff_actual < doff |=> diff_q; endproperty
   a_dwin: assert property (p_dwin)
      else $error("differential window output not set");
   c_freq: cover property (gend && tot > 0 ##1 freq_q);
   c_ana: cover property (ana_on < ana_off ##1 ana_q);
   c_diff: cover property (diff_delta > 0 ##1 diff_q);
endmodule
`default_nettype wire

// ==== bench/tts_pulse_src.sv ====
// Pulse source model driving the frequency trigger input
`timescale 1ns/1ps
`default_nettype none
module tts_pulse_src (
   // Clock
   input wire logic clk_sys,
   // Burst request
   input wire logic start,
   input wire logic [3:0] count,
   // Pulse line, idle low
   output logic pulse_out
);
   logic [4:0] left_ff = '0;
   // Odd counts give a high cycle, so every rise follows a low sample
   always @(posedge clk_sys) begin
      if (start)
         left_ff <= {count, 1'b0};
      else if (left_ff != 0)
         left_ff <= left_ff - 5'h01;
      pulse_out <= left_ff[0];
   end
endmodule
`default_nettype wire

// ==== bench/tb_threshold_trigger_set.sv ====
// Self-checking bench for the threshold trigger set
`timescale 1ns/1ps
`default_nettype none
module tb_threshold_trigger_set;
   localparam int GL = 20;
   logic clk_sys = 1'b0, sys_rst = 1'b1, start = 1'b0, pulse_in;
   logic [3:0] count = '0;
   logic [13:0] gate_time = 14'h0003, freq_on = '0, freq_off = '0;
   logic [9:0] analog_in = '0;
   logic [10:0] ana_gain = '0, diff_gain = '0;
   logic signed [14:0] ana_offset = '0, diff_offset = '0;
   tts_pkg::tts_val_t ana_on = '0, ana_off = '0, diff_on = '0;
   tts_pkg::tts_val_t diff_delta = '0, ana_actual, diff_actual;
   logic freq_q, ana_q, diff_q, eq = 0, ed = 0, fq = 0;
   logic [17:0] freq_rate;
   int mismatches = 0, checks_done = 0, cyc = 0, pa = 0, pd = 0;
   typedef struct {int sel; logic [17:0] val;} tts_note_t;
   tts_note_t notes[$], nt;
   event chk_ev;
   tts_top #(.TICK_CYCLES(4)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .pulse_in(pulse_in),
      .gate_time(gate_time), .freq_on(freq_on), .freq_off(freq_off),
      .freq_q(freq_q), .freq_rate(freq_rate), .analog_in(analog_in),
      .ana_gain(ana_gain), .ana_offset(ana_offset), .ana_on(ana_on),
      .ana_off(ana_off), .ana_q(ana_q), .ana_actual(ana_actual),
      .diff_gain(diff_gain), .diff_offset(diff_offset),
      .diff_on(diff_on), .diff_delta(diff_delta), .diff_q(diff_q),
      .diff_actual(diff_actual));
   tts_pulse_src u_src (.clk_sys(clk_sys), .start(start), .count(count),
      .pulse_out(pulse_in));
   initial forever #50 clk_sys = ~clk_sys;
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= sys_rst ? 0 : cyc + 1;
      if (cyc > 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic check(string nm, logic [17:0] seen, logic [17:0] want);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, want, seen);
      end
   endtask
   function automatic logic hy(logic q, int v, int on, int off, bit s);
      if (on < off) return v >= on && v < off;
      if (v > on) return 1'b1;
      if (s ? v < off : v <= off) return 1'b0;
      return q;
   endfunction
   function automatic int pick(int m, int b);
      return int'($urandom % m) - b;
   endfunction
   always begin
      @(chk_ev);
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         case (nt.sel)
            0: check("ana_actual", ana_actual, nt.val);
            1: check("ana_q", {17'h0, ana_q}, nt.val);
            2: check("diff_actual", diff_actual, nt.val);
            3: check("diff_q", {17'h0, diff_q}, nt.val);
            4: check("freq_rate", freq_rate, nt.val);
            default: check("freq_q", {17'h0, freq_q}, nt.val);
         endcase
      end
   end
   // Thresholds land beside the value, so the first update sees old actual
   task automatic ana_step();
      int a, g, o, act, on, off, g2, o2, dact, don, dl;
      a = pick(1001, 0);
      g = pick(1001, 0);
      o = pick(20001, 10000);
      g2 = pick(1001, 0);
      o2 = pick(20001, 10000);
      act = a * g / 100 + o;
      dact = a * g2 / 100 + o2;
      on = act + pick(5, 2);
      off = act + pick(5, 2);
      don = dact + pick(5, 2);
      dl = pick(7, 3);
      @(posedge clk_sys);
      analog_in <= 10'(a);
      ana_gain <= 11'(g);
      ana_offset <= 15'(o);
      ana_on <= 18'(on);
      ana_off <= 18'(off);
      diff_gain <= 11'(g2);
      diff_offset <= 15'(o2);
      diff_on <= 18'(don);
      diff_delta <= 18'(dl);
      eq = hy(hy(eq, pa, on, off, 0), act, on, off, 0);
      ed = hy(hy(ed, pd, don, don + dl, 1), dact, don, don + dl, 1);
      pa = act;
      pd = dact;
      repeat (3) @(posedge clk_sys);
      #1;
      notes.push_back('{0, 18'(act)});
      notes.push_back('{1, {17'h0, eq}});
      notes.push_back('{2, 18'(dact)});
      notes.push_back('{3, {17'h0, ed}});
      -> chk_ev;
   endtask
   initial begin
      int n, fo, ff;
      void'($urandom(76));
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (60) ana_step();
      // Pulse bursts sit mid-gate, clear of the boundary by a few cycles
      repeat (14) begin
         @(posedge clk_sys);
         n = pick(8, 0);
         fo = pick(9, 0);
         ff = pick(9, 0);
         while (cyc % GL != 0) @(posedge clk_sys);
         start <= 1'b1;
         count <= 4'(n);
         freq_on <= 14'(fo);
         freq_off <= 14'(ff);
         fq = hy(fq, n, fo, ff, 0);
         @(posedge clk_sys);
         start <= 1'b0;
         repeat (GL + 2) @(posedge clk_sys);
         #1;
         notes.push_back('{4, 18'(n)});
         notes.push_back('{5, {17'h0, fq}});
         -> chk_ev;
         fq = hy(fq, 0, fo, ff, 0);
      end
      repeat (2) @(posedge clk_sys);
      conclude();
   end
endmodule
bind tts_top tts_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .pulse_in(pulse_in),
   .gate_time(gate_time), .freq_on(freq_on), .freq_off(freq_off),
   .freq_q(freq_q), .freq_rate(freq_rate), .ana_on(ana_on),
   .ana_off(ana_off), .ana_q(ana_q), .ana_actual(ana_actual),
   .diff_on(diff_on), .diff_delta(diff_delta), .diff_q(diff_q),
   .diff_actual(diff_actual));
`default_nettype wire
